/* verilog/pec_pkg.sv */
// Package: constants, bus carriers and helpers for the power, energy and charge engine
// Summary of operation
// RQ1: Current derived from shunt sample and scale
// RQ2: Zero scale value gives zero current
// RQ3: Host quadruples scale value for narrow range
// RQ4: Host sets current step to max/2^19
// RQ5: Host step no more than eight times minimum
// RQ6: Current raw times step gives amperes
// RQ7: Power offered as a 24-bit result
// RQ8: Energy kept in 40-bit unsigned accumulator
// RQ9: Charge kept in 40-bit signed accumulator
// RQ10: Accumulators wrap to zero on overflow
// RQ11: Clear bit resets both accumulators anytime
// RQ12: Eight conversion times, 50 to 4120 us
// RQ13: Averaging counts; sample period is product
// RQ14: Range bit selects shunt full scale
// RQ15: Shunt and rail results are 20 bits
// RQ16: Power from current and rail; accumulate per sample
package pec_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned RES_W = 20;
   localparam int unsigned CAL_W = 16;
   localparam int unsigned PWR_W = 24;
   localparam int unsigned ACC_W = 40;
   localparam int unsigned SUM_W = 30;
   // Cycles from a calculation start to its done pulse
   localparam int DIV_LAT = 35;
   localparam int unsigned DIVN_W = 32;
   localparam int unsigned CFG_W = 8;
   // Fixed scale constant times the 312.5 nV shunt step equals 4096
   localparam int unsigned CURR_SHIFT = 12;
   // Rail step 195.3125 uV over power step 3.2 equals 2^-14
   localparam int unsigned PWR_SHIFT = 14;
   localparam logic [RES_W-1:0] CUR_MAX = 20'h7FFFF;
   localparam logic [PWR_W-1:0] PWR_MAX = 24'hFFFFFF;
   localparam int unsigned CLK_PERIOD_PS = 32'h00000FA0;
   localparam int unsigned PS_PER_US = 32'h000F4240;
   localparam int unsigned CYC_PER_US = PS_PER_US / CLK_PERIOD_PS;
   // Conversion times in microseconds, indexed by the time select field
   localparam logic [12:0] CONV_US [0:7] = '{13'h032, 13'h054, 13'h096, 13'h118,
                                            13'h21C, 13'h41C, 13'h81A, 13'h1018};
   // Averaging counts 1,4,16,64,128,256,512,1024 as shift amounts
   localparam logic [3:0] AVG_SHIFT [0:7] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                             4'h7, 4'h8, 4'h9, 4'hA};
   localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CAL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CUR = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PWR = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_ENE_LO = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_ENE_HI = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CHG_LO = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CHG_HI = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_SENSE = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_RAIL = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h28;
   localparam int unsigned CFG_RANGE_BIT = 0;
   localparam int unsigned CFG_CLR_BIT = 1;
   localparam int unsigned CFG_CT_LSB = 2;
   localparam int unsigned CFG_AVG_LSB = 5;
   localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
   localparam logic [CFG_W-1:0] CFG_KEEP = 8'hFD;
   localparam logic [CAL_W-1:0] CAL_RST = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [ADDR_W-1:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [ADDR_W-1:0] araddr;
      logic arvalid;
      logic rready;
   } pec_axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pec_axil_rsp_t;

   localparam pec_axil_rsp_t RSP_RST = '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0,
      bresp: 2'h0, arready: 1'b1, rvalid: 1'b0, rdata: 32'h00000000, rresp: 2'h0};

   function automatic logic [RES_W-1:0] abs20(input logic [RES_W-1:0] v);
      abs20 = v[RES_W-1] ? RES_W'(-v) : v;
   endfunction : abs20

   function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] strb);
      merge32 = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            merge32[8*i +: 8] = nw[8*i +: 8];
      end
   endfunction : merge32
endpackage : pec_pkg

/* verilog/pec_calc.sv */
// Serial divider and single-cycle multiplier that turn an averaged shunt sample into current and power
`timescale 1ns/1ps
module pec_calc
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [pec_pkg::RES_W-1:0] sense_avg,
   input wire logic [pec_pkg::RES_W-1:0] rail_avg,
   input wire logic [pec_pkg::CAL_W-1:0] cal,
   output logic done,
   output logic [pec_pkg::RES_W-1:0] current,
   output logic [pec_pkg::PWR_W-1:0] power
);
   import pec_pkg::*;
   typedef enum logic [1:0] {CS_IDLE, CS_DIV, CS_CUR, CS_PWR} pec_cs_t;
   pec_cs_t st_r, st_nxt;
   logic [DIVN_W-1:0] num_r, num_nxt, quo_r, quo_nxt, dvd_r, dvd_nxt;
   logic [CAL_W-1:0] rem_r, rem_nxt, cal_r, cal_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic neg_r, neg_nxt, done_r, done_nxt;
   logic [RES_W-1:0] rail_r, rail_nxt, cur_r, cur_nxt;
   logic [PWR_W-1:0] pwr_r, pwr_nxt;
   logic [CAL_W:0] rem_t;
   logic [2*RES_W-1:0] prod;

   always_comb
   begin
      st_nxt = st_r;
      num_nxt = num_r;
      quo_nxt = quo_r;
      dvd_nxt = dvd_r;
      rem_nxt = rem_r;
      cal_nxt = cal_r;
      cnt_nxt = cnt_r;
      neg_nxt = neg_r;
      rail_nxt = rail_r;
      cur_nxt = cur_r;
      pwr_nxt = pwr_r;
      done_nxt = 1'b0;
      rem_t = {rem_r, num_r[DIVN_W-1]};
      prod = {{RES_W{1'b0}}, abs20(cur_r)} * {{RES_W{1'b0}}, rail_r};
      case (st_r)
         CS_IDLE:
            if (start)
            begin
               // Magnitude scaled by 4096 over the scale value keeps current in steps
               neg_nxt = sense_avg[RES_W-1];
               num_nxt = {abs20(sense_avg), {CURR_SHIFT{1'b0}}}; // see RQ1
               dvd_nxt = {abs20(sense_avg), {CURR_SHIFT{1'b0}}};
               cal_nxt = cal;
               rail_nxt = rail_avg;
               rem_nxt = '0;
               quo_nxt = '0;
               cnt_nxt = '0;
               st_nxt = CS_DIV;
            end
         CS_DIV:
         begin
            num_nxt = {num_r[DIVN_W-2:0], 1'b0};
            if (rem_t >= {1'b0, cal_r})
            begin
               rem_nxt = CAL_W'(rem_t - {1'b0, cal_r});
               quo_nxt = {quo_r[DIVN_W-2:0], 1'b1};
            end
            else
            begin
               rem_nxt = rem_t[CAL_W-1:0];
               quo_nxt = {quo_r[DIVN_W-2:0], 1'b0};
            end
            cnt_nxt = 5'(cnt_r + 5'h01);
            if (cnt_r == 5'h1F)
               st_nxt = CS_CUR;
         end
         CS_CUR:
         begin
            if (cal_r == '0)
               cur_nxt = '0; // see RQ2
            else if (quo_r > {{(DIVN_W-RES_W){1'b0}}, CUR_MAX})
               cur_nxt = neg_r ? RES_W'(-CUR_MAX) : CUR_MAX;
            else
               cur_nxt = neg_r ? RES_W'(-quo_r[RES_W-1:0]) : quo_r[RES_W-1:0]; // see RQ6
            st_nxt = CS_PWR;
         end
         CS_PWR:
         begin
            // Oversized products clip rather than wrap so power never reads small
            if (prod[2*RES_W-1:PWR_SHIFT] > {{(2*RES_W-PWR_SHIFT-PWR_W){1'b0}}, PWR_MAX})
               pwr_nxt = PWR_MAX; // see RQ7
            else
               pwr_nxt = prod[PWR_SHIFT +: PWR_W]; // see RQ16
            done_nxt = 1'b1;
            st_nxt = CS_IDLE;
         end
         default:
            st_nxt = CS_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_r <= CS_IDLE;
         num_r <= '0;
         quo_r <= '0;
         dvd_r <= '0;
         rem_r <= '0;
         cal_r <= '0;
         cnt_r <= '0;
         neg_r <= 1'b0;
         rail_r <= '0;
         cur_r <= '0;
         pwr_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         num_r <= num_nxt;
         quo_r <= quo_nxt;
         dvd_r <= dvd_nxt;
         rem_r <= rem_nxt;
         cal_r <= cal_nxt;
         cnt_r <= cnt_nxt;
         neg_r <= neg_nxt;
         rail_r <= rail_nxt;
         cur_r <= cur_nxt;
         pwr_r <= pwr_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;
   assign current = cur_r;
   assign power = pwr_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_zero_scale: assert property (done_r && cal_r == '0 |-> cur_r == '0) // see RQ2
      else $error("current not zero with zero scale");
   a_div_bounds: assert property (done_r && cal_r != '0 && abs20(cur_r) < CUR_MAX // see RQ1
      |-> 48'(abs20(cur_r)) * 48'(cal_r) <= 48'(dvd_r)
          && 48'(dvd_r) < 48'(abs20(cur_r) + 20'h00001) * 48'(cal_r))
      else $error("current quotient out of bounds");
   a_power_bound: assert property (done_r && pwr_r != PWR_MAX // see RQ16
      |-> 40'(pwr_r) <= (40'(abs20(cur_r)) * 40'(rail_r)) >> PWR_SHIFT
          && (40'(abs20(cur_r)) * 40'(rail_r)) >> PWR_SHIFT < 40'(pwr_r) + 40'h1)
      else $error("power not product of current and rail");
   a_calc_latency: assert property (start && st_r == CS_IDLE |-> ##DIV_LAT done_r) // see RQ1
      else $error("calculation latency wrong");
endmodule : pec_calc

/* verilog/pec_engine.sv */
// Conversion timing, averaging, result registers, accumulators and AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module pec_engine
#(
   parameter int unsigned US_CYC = pec_pkg::CYC_PER_US
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire pec_pkg::pec_axil_req_t req,
   input wire logic [pec_pkg::RES_W-1:0] sense_code,
   input wire logic [pec_pkg::RES_W-1:0] rail_code,
   output pec_pkg::pec_axil_rsp_t rsp,
   output logic input_range_select
);
   import pec_pkg::*;

   pec_axil_rsp_t rsp_r, rsp_nxt;
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [ADDR_W-1:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt, rd_data, cfg_m, cal_m;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic wr_en, rd_ok, clr_pulse;
   logic [CFG_W-1:0] cfg_r, cfg_nxt;
   logic [CAL_W-1:0] cal_r, cal_nxt;
   logic [15:0] us_cnt_r, us_cnt_nxt, samp_cnt_r, samp_cnt_nxt;
   logic [12:0] conv_cnt_r, conv_cnt_nxt, conv_len;
   logic [9:0] avg_cnt_r, avg_cnt_nxt;
   logic [10:0] avg_len;
   logic [3:0] avg_sh;
   logic signed [SUM_W-1:0] sense_sum_r, sense_sum_nxt, sense_tot;
   logic [SUM_W-1:0] rail_sum_r, rail_sum_nxt, rail_tot;
   logic [RES_W-1:0] sense_res_r, sense_res_nxt, rail_res_r, rail_res_nxt;
   logic start_r, start_nxt, us_tick, conv_done, sample_done;
   logic [ACC_W-1:0] energy_r, energy_nxt, charge_r, charge_nxt;
   logic calc_done;
   logic [RES_W-1:0] cur;
   logic [PWR_W-1:0] pwr;

   // Bus slave: address and data are taken independently, the write happens once both are held
   always_comb
   begin
      rsp_nxt = rsp_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt = w_have_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      wr_en = 1'b0;
      if (req.awvalid && rsp_r.awready)
      begin
         waddr_nxt = req.awaddr;
         aw_have_nxt = 1'b1;
         rsp_nxt.awready = 1'b0;
      end
      if (req.wvalid && rsp_r.wready)
      begin
         wdata_nxt = req.wdata;
         wstrb_nxt = req.wstrb;
         w_have_nxt = 1'b1;
         rsp_nxt.wready = 1'b0;
      end
      if (aw_have_r && w_have_r && !rsp_r.bvalid)
      begin
         wr_en = 1'b1;
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         rsp_nxt.bvalid = 1'b1;
         rsp_nxt.bresp = (waddr_r == OFS_CFG || waddr_r == OFS_CAL) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rsp_r.bvalid && req.bready)
      begin
         rsp_nxt.bvalid = 1'b0;
         rsp_nxt.awready = 1'b1;
         rsp_nxt.wready = 1'b1;
      end
      if (req.arvalid && rsp_r.arready)
      begin
         rsp_nxt.arready = 1'b0;
         rsp_nxt.rvalid = 1'b1;
         rsp_nxt.rdata = rd_data;
         rsp_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rsp_r.rvalid && req.rready)
      begin
         rsp_nxt.rvalid = 1'b0;
         rsp_nxt.arready = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rsp_r <= RSP_RST;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end
      else
      begin
         rsp_r <= rsp_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r <= w_have_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
      end
   end

   // Accumulator halves are read separately; a sample may land between the two reads
   always_comb
   begin
      rd_data = '0;
      rd_ok = 1'b1;
      case (req.araddr)
         OFS_CFG: rd_data[CFG_W-1:0] = cfg_r;
         OFS_CAL: rd_data[CAL_W-1:0] = cal_r;
         OFS_CUR: rd_data[RES_W-1:0] = cur;
         OFS_PWR: rd_data[PWR_W-1:0] = pwr;
         OFS_ENE_LO: rd_data = energy_r[31:0];
         OFS_ENE_HI: rd_data[ACC_W-33:0] = energy_r[ACC_W-1:32];
         OFS_CHG_LO: rd_data = charge_r[31:0];
         OFS_CHG_HI: rd_data[ACC_W-33:0] = charge_r[ACC_W-1:32];
         OFS_SENSE: rd_data[RES_W-1:0] = sense_res_r; // see RQ15
         OFS_RAIL: rd_data[RES_W-1:0] = rail_res_r;
         OFS_STAT: rd_data[15:0] = samp_cnt_r;
         default: rd_ok = 1'b0;
      endcase
   end

   // Configuration; the clear bit is a write-one pulse and is never stored
   always_comb
   begin
      cfg_nxt = cfg_r;
      cal_nxt = cal_r;
      clr_pulse = 1'b0;
      cfg_m = merge32({{(32-CFG_W){1'b0}}, cfg_r}, wdata_r, wstrb_r);
      cal_m = merge32({{(32-CAL_W){1'b0}}, cal_r}, wdata_r, wstrb_r);
      if (wr_en && waddr_r == OFS_CFG)
      begin
         cfg_nxt = cfg_m[CFG_W-1:0] & CFG_KEEP;
         clr_pulse = cfg_m[CFG_CLR_BIT]; // see RQ11
      end
      if (wr_en && waddr_r == OFS_CAL)
         cal_nxt = cal_m[CAL_W-1:0];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cfg_r <= CFG_RST;
         cal_r <= CAL_RST;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         cal_r <= cal_nxt;
      end
   end

   assign input_range_select = cfg_r[CFG_RANGE_BIT]; // see RQ14

   // Conversion timing and averaging; a new time or count takes effect at once
   always_comb
   begin
      us_cnt_nxt = us_cnt_r;
      conv_cnt_nxt = conv_cnt_r;
      avg_cnt_nxt = avg_cnt_r;
      sense_sum_nxt = sense_sum_r;
      rail_sum_nxt = rail_sum_r;
      sense_res_nxt = sense_res_r;
      rail_res_nxt = rail_res_r;
      start_nxt = 1'b0;
      sample_done = 1'b0;
      conv_len = CONV_US[cfg_r[CFG_CT_LSB +: 3]];
      avg_sh = AVG_SHIFT[cfg_r[CFG_AVG_LSB +: 3]];
      avg_len = 11'(11'h001 << avg_sh);
      sense_tot = sense_sum_r + SUM_W'(signed'(sense_code));
      rail_tot = rail_sum_r + {{(SUM_W-RES_W){1'b0}}, rail_code};
      us_tick = (us_cnt_r >= 16'(US_CYC - 1));
      us_cnt_nxt = us_tick ? '0 : 16'(us_cnt_r + 16'h0001);
      // Greater-or-equal lets a shortened time end the running conversion promptly
      conv_done = us_tick && (conv_cnt_r >= 13'(conv_len - 13'h0001)); // see RQ12
      if (us_tick)
         conv_cnt_nxt = conv_done ? '0 : 13'(conv_cnt_r + 13'h0001);
      if (conv_done)
      begin
         sense_sum_nxt = sense_tot;
         rail_sum_nxt = rail_tot;
         avg_cnt_nxt = 10'(avg_cnt_r + 10'h001);
         if (11'(avg_cnt_r) >= 11'(avg_len - 11'h001)) // see RQ13
         begin
            sample_done = 1'b1;
            sense_res_nxt = RES_W'(sense_tot >>> avg_sh);
            rail_res_nxt = RES_W'(rail_tot >> avg_sh);
            sense_sum_nxt = '0;
            rail_sum_nxt = '0;
            avg_cnt_nxt = '0;
            start_nxt = 1'b1; // see RQ1
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         us_cnt_r <= '0;
         conv_cnt_r <= '0;
         avg_cnt_r <= '0;
         sense_sum_r <= '0;
         rail_sum_r <= '0;
         sense_res_r <= '0;
         rail_res_r <= '0;
         start_r <= 1'b0;
      end
      else
      begin
         us_cnt_r <= us_cnt_nxt;
         conv_cnt_r <= conv_cnt_nxt;
         avg_cnt_r <= avg_cnt_nxt;
         sense_sum_r <= sense_sum_nxt;
         rail_sum_r <= rail_sum_nxt;
         sense_res_r <= sense_res_nxt;
         rail_res_r <= rail_res_nxt;
         start_r <= start_nxt;
      end
   end

   pec_calc u_calc
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(start_r),
      .sense_avg(sense_res_r),
      .rail_avg(rail_res_r),
      .cal(cal_r),
      .done(calc_done),
      .current(cur),
      .power(pwr)
   );

   // Accumulators; a clear in the same cycle as a new sample keeps that sample
   always_comb
   begin
      energy_nxt = energy_r;
      charge_nxt = charge_r;
      samp_cnt_nxt = samp_cnt_r;
      if (calc_done)
      begin
         energy_nxt = ACC_W'(energy_r + {{(ACC_W-PWR_W){1'b0}}, pwr}); // see RQ8 RQ10
         charge_nxt = ACC_W'(charge_r + ACC_W'(signed'(cur))); // see RQ9
         samp_cnt_nxt = 16'(samp_cnt_r + 16'h0001);
      end
      if (clr_pulse)
      begin
         energy_nxt = calc_done ? {{(ACC_W-PWR_W){1'b0}}, pwr} : '0; // see RQ11
         charge_nxt = calc_done ? ACC_W'(signed'(cur)) : '0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         energy_r <= '0;
         charge_r <= '0;
         samp_cnt_r <= '0;
      end
      else
      begin
         energy_r <= energy_nxt;
         charge_r <= charge_nxt;
         samp_cnt_r <= samp_cnt_nxt;
      end
   end

   assign rsp = rsp_r;

   // Helper counters that let the timing checks measure whole periods
   logic [20:0] since_r, since_nxt;
   logic [10:0] seen_r, seen_nxt;
   logic per_ok_r, per_ok_nxt, avg_ok_r, avg_ok_nxt;

   always_comb
   begin
      since_nxt = conv_done ? '0 : 21'(since_r + 21'h000001);
      seen_nxt = sample_done ? '0 : (conv_done ? 11'(seen_r + 11'h001) : seen_r);
      per_ok_nxt = wr_en ? 1'b0 : (conv_done ? 1'b1 : per_ok_r);
      avg_ok_nxt = wr_en ? 1'b0 : (sample_done ? 1'b1 : avg_ok_r);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         since_r <= '0;
         seen_r <= '0;
         per_ok_r <= 1'b0;
         avg_ok_r <= 1'b0;
      end
      else
      begin
         since_r <= since_nxt;
         seen_r <= seen_nxt;
         per_ok_r <= per_ok_nxt;
         avg_ok_r <= avg_ok_nxt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_conv_period: assert property (conv_done && per_ok_r // see RQ12
      |-> since_r == 21'(int'(conv_len) * int'(US_CYC) - 1))
      else $error("conversion period wrong");
   a_avg_span: assert property (sample_done && avg_ok_r // see RQ13
      |-> 11'(seen_r + 11'h001) == avg_len)
      else $error("averaging count wrong");
   a_accum_clear: assert property (clr_pulse && !calc_done // see RQ11
      |=> energy_r == '0 && charge_r == '0)
      else $error("accumulators not cleared");
   a_energy_step: assert property (calc_done && !clr_pulse // see RQ10
      |=> energy_r == ACC_W'($past(energy_r) + {16'h0000, $past(pwr)}))
      else $error("energy step wrong");
   a_charge_step: assert property (calc_done && !clr_pulse // see RQ9
      |=> charge_r == ACC_W'($past(charge_r) + ACC_W'(signed'($past(cur)))))
      else $error("charge step wrong");
   a_range_drive: assert property (wr_en && waddr_r == OFS_CFG && wstrb_r[0] // see RQ14
      |=> input_range_select == $past(wdata_r[CFG_RANGE_BIT]))
      else $error("range select not applied");
   a_sample_start: assert property (sample_done |=> start_r ##DIV_LAT calc_done) // see RQ16
      else $error("sample did not produce results");
endmodule : pec_engine

/* verification/pec_host.sv */
// Host model: AXI4-Lite master that programs the engine and reads its results
`timescale 1ns/1ps
module pec_host
(
   input wire logic clk,
   output pec_pkg::pec_axil_req_t req,
   input wire pec_pkg::pec_axil_rsp_t rsp
);
   import pec_pkg::*;
   int tmo = 0;
   initial req = '0;
   // Base assumes step = max current / 2^19, rounded up no more than 8x
   function automatic logic [15:0] scale_for(input logic [13:0] b, input logic rng);
      return rng ? {b, 2'b00} : {2'b00, b};
   endfunction : scale_for
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (rsp.awready)
            req.awvalid <= 1'b0;
         if (rsp.wready)
            req.wvalid <= 1'b0;
      end while (!rsp.bvalid && n < 200);
      req.bready <= 1'b0;
      r = rsp.bresp;
      tmo += int'(n >= 200);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [33:0] r);
      int n;
      n = 0;
      @(posedge clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (rsp.arready)
            req.arvalid <= 1'b0;
      end while (!rsp.rvalid && n < 200);
      req.rready <= 1'b0;
      r = {rsp.rresp, rsp.rdata};
      tmo += int'(n >= 200);
   endtask : rd
endmodule : pec_host

/* verification/pec_engine_tb.sv */
// Self-checking bench for the power, energy and charge engine
`timescale 1ns/1ps
module pec_engine_tb;
   import pec_pkg::*;
   logic clk, sys_rst, irs;
   logic [19:0] sense_code, rail_code, x, rl, cur;
   pec_axil_req_t req;
   pec_axil_rsp_t rsp;
   logic [42:0] expq[$];
   logic [42:0] e;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;
   int i, c0;
   integer seed;
   logic [31:0] d;
   logic [13:0] base;
   logic [15:0] sc;
   logic [63:0] q, p, en, ch;
   int pper[10] = '{50, 84, 150, 200, 280, 540, 1052, 2074, 4120, 800};
   logic [7:0] pcfg[10] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
      8'h40};
   pec_engine #(.US_CYC(1)) DUT
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .req(req),
      .sense_code(sense_code),
      .rail_code(rail_code),
      .rsp(rsp),
      .input_range_select(irs)
   );
   pec_host host_m
   (
      .clk(clk),
      .req(req),
      .rsp(rsp)
   );
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
      cyc <= cyc + 1;
   initial
   begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end
   task automatic cmp(input string s, input logic [33:0] ex, input logic [33:0] g);
      total_checks++;
      if (g !== ex)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", s, ex, g);
      end
   endtask : cmp
   // Oldest note answers the response now on the bus; one transfer at a time
   always @(posedge clk)
   begin
      if ((rsp.rvalid && req.rready) || (rsp.bvalid && req.bready))
      begin
         e = expq.pop_front();
         if (e[34])
            cmp($sformatf("reg %h", e[42:35]), e[33:0],
               rsp.rvalid ? {rsp.rresp, rsp.rdata} : {rsp.bresp, 32'h0});
      end
   end
   task automatic rx(input logic [7:0] a, input logic [34:0] ex);
      logic [33:0] r;
      expq.push_back({a, ex});
      host_m.rd(a, r);
      d = r[31:0];
      if (host_m.tmo > 0)
         complete_run();
   endtask : rx
   task automatic wx(input logic [7:0] a, input logic [31:0] v, input logic [1:0] ex);
      logic [1:0] r;
      expq.push_back({a, 1'b1, ex, 32'h0});
      host_m.wr(a, v, r);
      if (host_m.tmo > 0)
         complete_run();
   endtask : wx
   // Returns just after the sample count has moved on by k
   task automatic stat_plus(input int k);
      logic [15:0] t;
      int n;
      rx(OFS_STAT, '0);
      t = d[15:0] + 16'(k);
      n = 0;
      while (d[15:0] != t && n < 3000)
      begin
         rx(OFS_STAT, '0);
         n++;
      end
      if (n >= 3000)
      begin
         n_mismatch++;
         complete_run();
      end
   endtask : stat_plus
   task automatic complete_run();
      n_mismatch += host_m.tmo;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   initial
   begin
      seed = 12716;
      sys_rst = 1'b1;
      sense_code = 20'h0;
      rail_code = 20'h0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rx(OFS_CFG, {1'b1, RESP_OKAY, 32'h0});
      rx(OFS_CAL, {1'b1, RESP_OKAY, 32'h0});
      rx(8'h30, {1'b1, RESP_SLVERR, 32'h0});
      wx(OFS_CUR, 32'h1, RESP_SLVERR);
      sense_code <= 20'h12345;
      rail_code <= 20'h40000;
      stat_plus(2);
      rx(OFS_CUR, {1'b1, RESP_OKAY, 32'h0});
      for (i = 0; i < 4; i++)
      begin
         x = 20'($random(seed));
         rl = 20'($random(seed));
         base = 14'($random(seed)) | 14'h0100;
         sc = host_m.scale_for(base, i[0]);
         sense_code <= x;
         rail_code <= rl;
         wx(OFS_CAL, {16'h0, sc}, RESP_OKAY);
         wx(OFS_CFG, {31'h0, i[0]}, RESP_OKAY);
         cmp("range", {33'h0, i[0]}, {33'h0, irs});
         cur = x[19] ? -x : x;
         q = (64'(cur) * 4096) / sc;
         if (q > 64'h7FFFF)
            q = 64'h7FFFF;
         p = (q * rl) >> 14;
         if (p > 64'hFFFFFF)
            p = 64'hFFFFFF;
         cur = x[19] ? -q[19:0] : q[19:0];
         en = p * 3;
         ch = {{44{cur[19]}}, cur} * 3;
         stat_plus(2);
         wx(OFS_CFG, {30'h0, 1'b1, i[0]}, RESP_OKAY);
         stat_plus(3);
         // Accumulators first: they move again one sample period later
         rx(OFS_ENE_LO, {1'b1, RESP_OKAY, en[31:0]});
         rx(OFS_ENE_HI, {1'b1, RESP_OKAY, 24'h0, en[39:32]});
         rx(OFS_CHG_LO, {1'b1, RESP_OKAY, ch[31:0]});
         rx(OFS_CHG_HI, {1'b1, RESP_OKAY, 24'h0, ch[39:32]});
         rx(OFS_CUR, {1'b1, RESP_OKAY, 12'h0, cur});
         rx(OFS_PWR, {1'b1, RESP_OKAY, 8'h0, p[23:0]});
         rx(OFS_SENSE, {1'b1, RESP_OKAY, 12'h0, x});
         rx(OFS_RAIL, {1'b1, RESP_OKAY, 12'h0, rl});
         rx(OFS_CFG, {1'b1, RESP_OKAY, 31'h0, i[0]});
      end
      for (i = 0; i < 10; i++)
      begin
         wx(OFS_CFG, {24'h0, pcfg[i]}, RESP_OKAY);
         stat_plus(1);
         c0 = cyc;
         stat_plus(1);
         c0 = cyc - c0;
         // Polling blurs each edge by a few cycles, hence the window
         cmp("period", 34'(pper[i]),
            34'((c0 > pper[i] - 9 && c0 < pper[i] + 9) ? pper[i] : c0));
      end
      complete_run();
   end
endmodule : pec_engine_tb
